//--- src/wakeup_timer_low_power_card_detect.sv
// Purpose: 16-bit wake-up down counter with card detect, trim and wake actions
// Assumes: register port and detect inputs are on clk_sys_i; oscillator is async
// Notes: all outputs are flip-flops; action outputs are one-cycle pulses

module wakeup_timer_low_power_card_detect
    import wake_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic low_freq_oscillator_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic irq_flag_clear_i,
    input wire logic field_on_timer_expired_i,
    input wire logic card_present_i,
    output logic [7:0] reg_rdata_o,
    output logic wake_timer_irq_flag_o,
    output logic wake_o,
    output logic trim_start_o,
    output logic field_on_timer_start_o,
    output logic rf_field_on_o,
    output logic card_irq_o,
    output logic power_down_req_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [0:0] {DETECT_IDLE, DETECT_FIELD} detect_state_t;

    logic osc_meta_reg;
    logic osc_sync_reg;
    logic osc_last_reg;
    logic osc_edge;
    logic tick;
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] reload_high_reg;
    logic [7:0] reload_high_next;
    logic [7:0] reload_low_reg;
    logic [7:0] reload_low_next;
    logic [COUNT_WIDTH-1:0] count_reg;
    logic [COUNT_WIDTH-1:0] count_next;
    logic [COUNT_WIDTH-1:0] reload_value;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq_flag_reg;
    logic irq_flag_next;
    logic wake_reg;
    logic trim_reg;
    logic field_start_reg;
    logic field_on_reg;
    logic field_on_next;
    logic card_irq_reg;
    logic power_down_reg;
    logic wake_next;
    logic trim_next;
    logic field_start_next;
    logic card_irq_next;
    logic power_down_next;
    detect_state_t detect_reg;
    detect_state_t detect_next;
    logic ctrl_write;
    logic start_event;
    logic underflow;
    logic detect_done;

    // ------------------------------------------------------------
    // Oscillator synchroniser and edge detect
    // ------------------------------------------------------------
    // Edge detect reads only the second and third stages, never the metastable one
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_last_reg <= 1'b0;
        end else begin
            osc_meta_reg <= low_freq_oscillator_i;
            osc_sync_reg <= osc_meta_reg;
            osc_last_reg <= osc_sync_reg;
        end
    end

    assign osc_edge = osc_sync_reg & ~osc_last_reg;

    wake_prescaler u_prescaler (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .osc_edge_i(osc_edge),
        .restart_i(start_event),
        .clock_select_i(control_reg[CLK_SEL_MSB:CLK_SEL_LSB]),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    // A start is a strobed write with the run bit set, whether the timer was stopped or running
    assign ctrl_write = reg_wr_i && (reg_addr_i == ADDR_CONTROL);
    assign start_event = ctrl_write && reg_wdata_i[BIT_RUN_CHANGE] && reg_wdata_i[BIT_RUNNING];
    assign reload_value = {reload_high_reg, reload_low_reg};
    // Reload value of one or zero also ends on the very next tick
    assign underflow = tick && control_reg[BIT_RUNNING] && (count_reg <= 16'h0001) && !ctrl_write;
    assign detect_done = (detect_reg == DETECT_FIELD) && field_on_timer_expired_i;

    // ------------------------------------------------------------
    // Control, reload and counter
    // ------------------------------------------------------------
    // A control write is taken ahead of a tick in the same cycle
    always_comb begin
        control_next = control_reg;
        reload_high_next = reload_high_reg;
        reload_low_next = reload_low_reg;
        count_next = count_reg;
        if (ctrl_write) begin
            control_next[5:0] = reg_wdata_i[5:0];
            if (reg_wdata_i[BIT_RUN_CHANGE]) begin
                control_next[BIT_RUNNING] = reg_wdata_i[BIT_RUNNING];
            end
            if (start_event) begin
                count_next = reload_value;
            end
        end else if (underflow) begin
            if (control_reg[BIT_AUTO_RELOAD] || control_reg[BIT_AUTO_CARD]) begin
                count_next = reload_value;
            end else begin
                count_next = '0;
                control_next[BIT_RUNNING] = 1'b0;
            end
        end else if (tick && control_reg[BIT_RUNNING]) begin
            count_next = count_reg - 16'h0001;
        end
        // Reload bytes only change storage; count picks them up at next start or at an underflow with auto reload or auto card detect set
        if (reg_wr_i && (reg_addr_i == ADDR_RELOAD_HIGH)) begin
            reload_high_next = reg_wdata_i;
        end
        if (reg_wr_i && (reg_addr_i == ADDR_RELOAD_LOW)) begin
            reload_low_next = reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_reg <= CONTROL_RESET;
            reload_high_reg <= RELOAD_RESET;
            reload_low_reg <= RELOAD_RESET;
            count_reg <= '0;
        end else begin
            control_reg <= control_next;
            reload_high_reg <= reload_high_next;
            reload_low_reg <= reload_low_next;
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    // Strobe bit is write-only and reads zero
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CONTROL: rdata_next = control_reg & 8'hBF;
                ADDR_RELOAD_HIGH: rdata_next = reload_high_reg;
                ADDR_RELOAD_LOW: rdata_next = reload_low_reg;
                ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
                ADDR_COUNT_LOW: rdata_next = count_reg[7:0];
                default: rdata_next = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= READ_UNMAPPED;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Underflow actions and card detect sequence
    // ------------------------------------------------------------
    // Flag set wins over a clear arriving in the same cycle
    always_comb begin
        irq_flag_next = irq_flag_reg;
        if (irq_flag_clear_i) begin
            irq_flag_next = 1'b0;
        end
        if (underflow) begin
            irq_flag_next = 1'b1;
        end
        wake_next = underflow && control_reg[BIT_AUTO_WAKE];
        trim_next = underflow && control_reg[BIT_AUTO_TRIM];
        field_start_next = 1'b0;
        field_on_next = field_on_reg;
        card_irq_next = 1'b0;
        power_down_next = 1'b0;
        detect_next = detect_reg;
        case (detect_reg)
            DETECT_IDLE: begin
                if (underflow && control_reg[BIT_AUTO_CARD]) begin
                    field_start_next = 1'b1;
                    field_on_next = 1'b1;
                    detect_next = DETECT_FIELD;
                end
            end
            DETECT_FIELD: begin
                // Field stays on until the field-on timer expires
                if (detect_done) begin
                    field_on_next = 1'b0;
                    detect_next = DETECT_IDLE;
                    card_irq_next = card_present_i;
                    power_down_next = !card_present_i && control_reg[BIT_AUTO_WAKE];
                end
            end
            default: begin
                field_on_next = 1'b0;
                detect_next = DETECT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_flag_reg <= 1'b0;
            wake_reg <= 1'b0;
            trim_reg <= 1'b0;
            field_start_reg <= 1'b0;
            field_on_reg <= 1'b0;
            card_irq_reg <= 1'b0;
            power_down_reg <= 1'b0;
            detect_reg <= DETECT_IDLE;
        end else begin
            irq_flag_reg <= irq_flag_next;
            wake_reg <= wake_next;
            trim_reg <= trim_next;
            field_start_reg <= field_start_next;
            field_on_reg <= field_on_next;
            card_irq_reg <= card_irq_next;
            power_down_reg <= power_down_next;
            detect_reg <= detect_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign wake_timer_irq_flag_o = irq_flag_reg;
    assign wake_o = wake_reg;
    assign trim_start_o = trim_reg;
    assign field_on_timer_start_o = field_start_reg;
    assign rf_field_on_o = field_on_reg;
    assign card_irq_o = card_irq_reg;
    assign power_down_req_o = power_down_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_underflow;
        tick && control_reg[BIT_RUNNING] && (count_reg <= 16'h0001) && !ctrl_write;
    endsequence

    sequence seq_detect_end(logic found);
        (detect_reg == DETECT_FIELD) && field_on_timer_expired_i && (card_present_i == found);
    endsequence

    AST_RUN_READBACK: assert property (
        (reg_rd_i && reg_addr_i == ADDR_CONTROL) |=> (reg_rdata_o[7] == $past(control_reg[BIT_RUNNING])))
        else $error("running bit readback wrong");

    AST_RUN_NEEDS_STROBE: assert property (
        (ctrl_write && !reg_wdata_i[BIT_RUN_CHANGE] && !underflow) |=> $stable(control_reg[BIT_RUNNING]))
        else $error("running bit changed without strobe");

    AST_TRIM_ON_UNDERFLOW: assert property (
        (seq_underflow and control_reg[BIT_AUTO_TRIM]) |=> trim_start_o ##1 !trim_start_o)
        else $error("trim pulse missing");

    AST_CARD_FOUND_IRQ: assert property (
        seq_detect_end(1'b1) |=> card_irq_o && !power_down_req_o && !rf_field_on_o)
        else $error("card found without request");

    AST_NO_CARD_POWER_DOWN: assert property (
        (seq_detect_end(1'b0) and control_reg[BIT_AUTO_WAKE]) |=> power_down_req_o && !card_irq_o)
        else $error("power-down request missing");

    AST_NO_GAP_RESTART: assert property (
        (seq_underflow and control_reg[BIT_AUTO_CARD]) |=> control_reg[BIT_RUNNING] && count_reg == reload_value)
        else $error("card detect restart gap");

    AST_FIELD_START: assert property (
        (seq_underflow and control_reg[BIT_AUTO_CARD] and detect_reg == DETECT_IDLE)
        |=> field_on_timer_start_o && rf_field_on_o)
        else $error("field-on timer not started");

    AST_STOP_AT_ZERO: assert property (
        (seq_underflow and !control_reg[BIT_AUTO_RELOAD] and !control_reg[BIT_AUTO_CARD])
        |=> !control_reg[BIT_RUNNING] && count_reg == 16'h0000)
        else $error("timer did not stop at zero");

    AST_IRQ_SET: assert property (
        seq_underflow |=> wake_timer_irq_flag_o ##1 (wake_timer_irq_flag_o || $past(irq_flag_clear_i)))
        else $error("irq flag not set on underflow");

    AST_WAKE_PULSE: assert property (
        (seq_underflow and control_reg[BIT_AUTO_WAKE]) |=> wake_o)
        else $error("wake pulse missing");

    AST_RELOAD_NO_EFFECT: assert property (
        (reg_wr_i && reg_addr_i == ADDR_RELOAD_LOW && !tick && !ctrl_write) |=> $stable(count_reg))
        else $error("reload write changed count");

    AST_COUNT_READ: assert property (
        (reg_rd_i && reg_addr_i == ADDR_COUNT_HIGH) |=> reg_rdata_o == $past(count_reg[15:8]))
        else $error("count high readback wrong");

    AST_DECREMENT: assert property (
        (tick && control_reg[BIT_RUNNING] && count_reg > 16'h0001 && !ctrl_write)
        |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("counter did not decrement");

endmodule

//--- shared/wake_timer_pkg.sv
// Purpose: constants shared by the wake-up timer and its prescaler
// Assumes: 8-bit register port, one system clock

package wake_timer_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h23;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h24;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h25;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h26;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h27;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int BIT_RUNNING = 7;
    localparam int BIT_RUN_CHANGE = 6;
    localparam int BIT_AUTO_TRIM = 5;
    localparam int BIT_AUTO_CARD = 4;
    localparam int BIT_AUTO_RELOAD = 3;
    localparam int BIT_AUTO_WAKE = 2;
    localparam int CLK_SEL_MSB = 1;
    localparam int CLK_SEL_LSB = 0;

    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int COUNT_WIDTH = 16;

    // ------------------------------------------------------------
    // Prescaler divisors, minus one, per clock select code
    // ------------------------------------------------------------
    localparam logic [4:0] DIV_TERM_1 = 5'h00;
    localparam logic [4:0] DIV_TERM_8 = 5'h07;
    localparam logic [4:0] DIV_TERM_16 = 5'h0F;
    localparam logic [4:0] DIV_TERM_32 = 5'h1F;

endpackage

//--- src/wake_prescaler.sv
// Purpose: divide oscillator edges into timer ticks
// Assumes: osc_edge_i is a one-cycle pulse in the system clock domain
// Notes: divider restarts on restart_i so each start sees a full first period

module wake_prescaler
    import wake_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic osc_edge_i,
    input wire logic restart_i,
    input wire logic [1:0] clock_select_i,
    output logic tick_o
);

    logic [4:0] div_reg;
    logic [4:0] div_next;
    logic tick_reg;
    logic tick_next;

    // Terminal count for a select code
    function automatic logic [4:0] term_of(input logic [1:0] sel);
        case (sel)
            2'h0: term_of = DIV_TERM_1;
            2'h1: term_of = DIV_TERM_8;
            2'h2: term_of = DIV_TERM_16;
            default: term_of = DIV_TERM_32;
        endcase
    endfunction

    // Count oscillator edges; tick on the last edge of each period
    always_comb begin
        div_next = div_reg;
        tick_next = 1'b0;
        if (restart_i) begin
            div_next = 5'h00;
        end else if (osc_edge_i) begin
            if (div_reg >= term_of(clock_select_i)) begin
                div_next = 5'h00;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= 5'h00;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench for the wake-up timer block
// Assumes: oscillator edges come from the bench and are slow against the system clock
// Notes: random reload values come from a fixed-seed LFSR; pulses are counted, not sampled

`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %s expected %0h seen %0h", name, exp, got); end end

module tb_top
    import wake_timer_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals and counters
    // ----------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic osc = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq_clr = 1'b0;
    logic expired = 1'b0;
    logic card_present = 1'b0;
    logic [7:0] rdata;
    logic irq_flag, wake, trim, fstart, rf_on, card_irq, pdown;
    int bad_count = 0;
    int checks_done = 0;
    int n_wake = 0, n_trim = 0, n_fstart = 0, n_card = 0, n_pdown = 0;
    logic [31:0] lfsr_state = 32'h90908F41;
    logic [15:0] rl, rl2;

    wakeup_timer_low_power_card_detect dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .low_freq_oscillator_i(osc),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
        .irq_flag_clear_i(irq_clr), .field_on_timer_expired_i(expired), .card_present_i(card_present),
        .reg_rdata_o(rdata), .wake_timer_irq_flag_o(irq_flag), .wake_o(wake), .trim_start_o(trim),
        .field_on_timer_start_o(fstart), .rf_field_on_o(rf_on), .card_irq_o(card_irq),
        .power_down_req_o(pdown)
    );

    // Clock, 5 ns period
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Action outputs are one-cycle pulses, so count them every edge
    always @(posedge clk_sys_i) begin
        n_wake <= n_wake + int'(wake);
        n_trim <= n_trim + int'(trim);
        n_fstart <= n_fstart + int'(fstart);
        n_card <= n_card + int'(card_irq);
        n_pdown <= n_pdown + int'(pdown);
    end

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Count left after a number of oscillator edges under a clock select code
    function automatic logic [15:0] exp_count(input logic [15:0] start, input int edges, input logic [1:0] code);
        int div;
        div = (code == 2'b00) ? 1 : (code == 2'b01) ? 8 : (code == 2'b10) ? 16 : 32;
        return start - 16'(edges / div);
    endfunction

    // ----------------------------------------------------------------
    // Drivers: every task starts and ends just after a rising edge
    // ----------------------------------------------------------------
    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask

    // One idle cycle after each access keeps strobes from being set twice in a step
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        step();
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        step();
        d = rdata;
        reg_rd = 1'b0;
        step();
    endtask

    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] v;
        reg_read(a, v);
        `CHK(name, exp, v)
    endtask

    task automatic check_count(input logic [15:0] exp);
        check_reg(ADDR_COUNT_HIGH, exp[15:8], "count_high");
        check_reg(ADDR_COUNT_LOW, exp[7:0], "count_low");
    endtask

    // Oscillator edges spaced wide enough for the synchroniser, then let them land
    task automatic osc_edges(input int n);
        repeat (n) begin
            osc = 1'b1;
            repeat (4) step();
            osc = 1'b0;
            repeat (4) step();
        end
        repeat (4) step();
    endtask

    task automatic set_reload(input logic [15:0] v);
        reg_write(ADDR_RELOAD_HIGH, v[15:8]);
        reg_write(ADDR_RELOAD_LOW, v[7:0]);
    endtask

    task automatic detect_end(input logic card);
        card_present = card;
        expired = 1'b1;
        step();
        expired = 1'b0;
        step();
    endtask

    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the longest expected run
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        step();
        // Reset values, unmapped read, read-only count
        check_reg(ADDR_CONTROL, CONTROL_RESET, "control_reset");
        check_reg(ADDR_RELOAD_HIGH, RELOAD_RESET, "reload_high_reset");
        check_count(16'h0000);
        check_reg(8'h30, READ_UNMAPPED, "unmapped");
        reg_write(ADDR_COUNT_LOW, 8'h5A);
        check_count(16'h0000);
        // Run bit without the strobe must not start the timer
        reg_write(ADDR_CONTROL, 8'h88);
        check_reg(ADDR_CONTROL, 8'h08, "control_no_strobe");
        // Random reloads: load at start, later writes leave the count alone
        repeat (4) begin
            lfsr_state = lfsr_next(lfsr_state);
            rl = lfsr_state[15:0] | 16'h0100;
            rl2 = lfsr_state[31:16];
            set_reload(rl);
            reg_write(ADDR_CONTROL, 8'hC0);
            check_reg(ADDR_CONTROL, 8'h80, "control_running");
            check_count(rl);
            set_reload(rl2);
            check_reg(ADDR_RELOAD_LOW, rl2[7:0], "reload_low_rw");
            check_count(rl);
            osc_edges(1);
            check_count(rl - 16'h0001);
            reg_write(ADDR_CONTROL, 8'h40);
            check_reg(ADDR_CONTROL, 8'h00, "control_stopped");
        end
        // Every clock select code over the same edge count; stop must hold the count
        for (int c = 0; c < 4; c++) begin
            set_reload(16'h1000);
            reg_write(ADDR_CONTROL, 8'hC0 | 8'(c));
            osc_edges(64);
            check_count(exp_count(16'h1000, 64, 2'(c)));
            reg_write(ADDR_CONTROL, 8'h40 | 8'(c));
            osc_edges(8);
            check_count(exp_count(16'h1000, 64, 2'(c)));
        end
        // Auto reload with auto wake; software keeps bit 2 set to re-enter power-down
        set_reload(16'h0003);
        reg_write(ADDR_CONTROL, 8'hCC);
        osc_edges(2);
        `CHK("irq_early", 1'b0, irq_flag)
        osc_edges(1);
        `CHK("irq_flag", 1'b1, irq_flag)
        `CHK("wake_count", 1, n_wake)
        check_count(16'h0003);
        check_reg(ADDR_CONTROL, 8'h8C, "control_reloaded");
        osc_edges(3);
        `CHK("wake_count2", 2, n_wake)
        irq_clr = 1'b1;
        step();
        irq_clr = 1'b0;
        step();
        `CHK("irq_cleared", 1'b0, irq_flag)
        // One-shot: stop at zero
        reg_write(ADDR_CONTROL, 8'hC4);
        osc_edges(3);
        check_count(16'h0000);
        check_reg(ADDR_CONTROL, 8'h04, "control_oneshot");
        `CHK("irq_oneshot", 1'b1, irq_flag)
        // Trim on underflow; card detect stays off so the field-on timer is free
        reg_write(ADDR_CONTROL, 8'hE8);
        osc_edges(3);
        `CHK("trim_count", 1, n_trim)
        `CHK("wake_off", 3, n_wake)
        reg_write(ADDR_CONTROL, 8'h40);
        // Card detect, no card then a card
        reg_write(ADDR_CONTROL, 8'hD4);
        osc_edges(3);
        `CHK("field_start", 1, n_fstart)
        `CHK("field_on", 1'b1, rf_on)
        check_reg(ADDR_CONTROL, 8'h94, "detect_restart");
        check_count(16'h0003);
        detect_end(1'b0);
        `CHK("power_down", 1, n_pdown)
        `CHK("field_off", 1'b0, rf_on)
        osc_edges(3);
        `CHK("field_start2", 2, n_fstart)
        detect_end(1'b1);
        `CHK("card_irq", 1, n_card)
        `CHK("stay_active", 1, n_pdown)
        // An underflow during a running detection must not start a second one
        osc_edges(3);
        `CHK("field_start3", 3, n_fstart)
        osc_edges(3);
        `CHK("field_busy", 3, n_fstart)
        `CHK("field_held", 1'b1, rf_on)
        detect_end(1'b1);
        `CHK("card_irq2", 2, n_card)
        // Reset in mid-run clears control and count
        rst_n_i = 1'b0;
        step();
        rst_n_i = 1'b1;
        step();
        check_reg(ADDR_CONTROL, CONTROL_RESET, "control_rereset");
        check_count(16'h0000);
        end_sim();
    end

endmodule
